// file: design/wsyn_detector.sv
// TCP SYN wake detector: APB registers, frame parser and wake control
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module wsyn_detector (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // MAC receive stream, checks valid with eof
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_sof_in,
  input wire logic rx_eof_in,
  input wire logic rx_fcs_ok_in,
  input wire logic rx_ip_csum_ok_in,
  input wire logic rx_tcp_csum_ok_in,
  // Other wake sources
  input wire logic [4:0] wake_event_in,
  // Receive FIFO write side
  output logic fifo_valid_out,
  output logic [7:0] fifo_data_out,
  output logic fifo_last_out,
  output logic fifo_keep_out,
  // Power
  output logic remote_wakeup_out,
  output logic suspended_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    wsyn_pkg::wsyn_power_type power;
    logic [1:0] sleep_select;
    logic [7:0] en_one;
    logic [7:0] sts_one;
    logic [1:0] en_two;
    logic [1:0] sts_two;
    logic [47:0] station;
    logic [31:0] v4_source_match;
    logic [31:0] v4_dest_match;
    logic [31:0] v4_port_match;
    logic [127:0] v6_source_match;
    logic [127:0] v6_dest_match;
    logic [31:0] v6_port_match;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [13:0] cnt;
    logic [15:0] etype;
    logic ip_ok;
    logic [13:0] l4_start;
    logic [7:0] nh;
    logic ext_pending;
    logic syn;
    logic started_normal;
    logic remote_wakeup;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic fifo_last;
    logic fifo_keep;
  } wsyn_state_type;

  wsyn_state_type s;
  wsyn_state_type next_s;
  logic [1:0] rst_pipe;
  logic rst_n;

  // Reset is released through two flops, asserted at once
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ****************************************
  // Field collection
  // ****************************************
  wsyn_rx_if rx_bus ();
  assign rx_bus.valid = rx_valid_in;
  assign rx_bus.data = rx_data_in;
  assign rx_bus.sof = rx_sof_in;
  assign rx_bus.eof = rx_eof_in;

  logic [13:0] idx;
  logic is_v4;
  logic is_v6;
  logic take_da;
  logic take_src;
  logic take_dst;
  logic take_ports;
  logic l4_ready;
  logic [47:0] da_field;
  logic [127:0] src_field;
  logic [127:0] dst_field;
  logic [31:0] port_field;

  assign idx = rx_sof_in ? 14'h0000 : s.cnt;
  assign is_v4 = s.etype == wsyn_pkg::ETYPE_V4;
  assign is_v6 = s.etype == wsyn_pkg::ETYPE_V6;
  // Ports and flags only count once the header chain has reached TCP
  assign l4_ready = s.ip_ok && (s.nh == wsyn_pkg::PROTO_TCP) && !s.ext_pending;
  assign take_da = idx < wsyn_pkg::OFS_DA_END;
  assign take_src = is_v4 ? (idx >= wsyn_pkg::OFS_V4_SRC && idx < wsyn_pkg::OFS_V4_SRC + wsyn_pkg::LEN_V4_ADDR)
                          : (idx >= wsyn_pkg::OFS_V6_SRC && idx < wsyn_pkg::OFS_V6_SRC + wsyn_pkg::LEN_V6_ADDR);
  assign take_dst = is_v4 ? (idx >= wsyn_pkg::OFS_V4_DST && idx < wsyn_pkg::OFS_V4_DST + wsyn_pkg::LEN_V4_ADDR)
                          : (idx >= wsyn_pkg::OFS_V6_DST && idx < wsyn_pkg::OFS_V6_DST + wsyn_pkg::LEN_V6_ADDR);
  assign take_ports = l4_ready && idx >= s.l4_start && idx < s.l4_start + wsyn_pkg::LEN_PORTS;

  wsyn_field_grab #(.BYTES(6)) grab_da (.clock_in(clock_in), .rst_n_in(rst_n), .rx(rx_bus.sink),
    .take_in(take_da), .field_out(da_field));
  wsyn_field_grab #(.BYTES(16)) grab_src (.clock_in(clock_in), .rst_n_in(rst_n), .rx(rx_bus.sink),
    .take_in(take_src), .field_out(src_field));
  wsyn_field_grab #(.BYTES(16)) grab_dst (.clock_in(clock_in), .rst_n_in(rst_n), .rx(rx_bus.sink),
    .take_in(take_dst), .field_out(dst_field));
  wsyn_field_grab #(.BYTES(4)) grab_ports (.clock_in(clock_in), .rst_n_in(rst_n), .rx(rx_bus.sink),
    .take_in(take_ports), .field_out(port_field));

  // ****************************************
  // Match comparisons
  // ****************************************
  logic [5:0] hit;
  wsyn_field_cmp #(.WIDTH(32)) cmp_v4_src (.match_in(s.v4_source_match), .value_in(src_field[31:0]),
    .hit_out(hit[0]));
  wsyn_field_cmp #(.WIDTH(32)) cmp_v4_dst (.match_in(s.v4_dest_match), .value_in(dst_field[31:0]),
    .hit_out(hit[1]));
  wsyn_field_cmp #(.WIDTH(32)) cmp_v4_ports (.match_in(s.v4_port_match), .value_in(port_field),
    .hit_out(hit[2]));
  wsyn_field_cmp #(.WIDTH(128)) cmp_v6_src (.match_in(s.v6_source_match), .value_in(src_field),
    .hit_out(hit[3]));
  wsyn_field_cmp #(.WIDTH(128)) cmp_v6_dst (.match_in(s.v6_dest_match), .value_in(dst_field),
    .hit_out(hit[4]));
  wsyn_field_cmp #(.WIDTH(32)) cmp_v6_ports (.match_in(s.v6_port_match), .value_in(port_field),
    .hit_out(hit[5]));

  // ****************************************
  // Wake decision
  // ****************************************
  logic frame_end;
  logic sleep_ok;
  logic addr_ok;
  logic tcp_ok;
  logic v4_wake;
  logic v6_wake;
  logic bcast_wake;
  logic pfda_wake;
  logic [4:0] ext_wake;
  logic any_wake;
  logic [7:0] set_one;
  logic [1:0] set_two;

  assign frame_end = rx_valid_in && rx_eof_in;
  // Sleep state two has no SYN detection
  assign sleep_ok = (s.power == wsyn_pkg::WSYN_SUSPEND) && (s.sleep_select != wsyn_pkg::SLEEP_STATE_TWO);
  // Multicast bit also covers broadcast
  assign addr_ok = (da_field == s.station) || da_field[wsyn_pkg::DA_MCAST_BIT];
  assign tcp_ok = frame_end && s.syn && rx_fcs_ok_in && rx_tcp_csum_ok_in;
  assign v4_wake = s.en_two[wsyn_pkg::W2_V4] && sleep_ok && tcp_ok && addr_ok && is_v4 && l4_ready &&
                   rx_ip_csum_ok_in && (&hit[2:0]);
  assign v6_wake = s.en_two[wsyn_pkg::W2_V6] && sleep_ok && tcp_ok && addr_ok && is_v6 && l4_ready &&
                   (&hit[5:3]);
  assign bcast_wake = s.en_one[wsyn_pkg::W1_BCAST] && sleep_ok && frame_end && rx_fcs_ok_in && (&da_field);
  assign pfda_wake = s.en_one[wsyn_pkg::W1_PERFECT_DA] && sleep_ok && frame_end && rx_fcs_ok_in &&
                     (da_field == s.station);
  assign ext_wake = s.en_one[wsyn_pkg::W1_EXT_LSB +: wsyn_pkg::EXT_EVENTS] & wake_event_in &
                    {wsyn_pkg::EXT_EVENTS{sleep_ok}};
  assign set_one = {ext_wake, 1'b0, pfda_wake, bcast_wake};
  assign set_two = {v6_wake, v4_wake};
  assign any_wake = (|set_one) || (|set_two);

  // ****************************************
  // APB decode
  // ****************************************
  logic access;
  logic wr;
  logic [31:0] rd_word;
  logic rd_hit;

  assign access = psel_in && penable_in;
  assign wr = access && s.pready && pwrite_in;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr_in)
      wsyn_pkg::ADDR_POWER_MGMT_CONTROL: begin
        rd_word[wsyn_pkg::PMC_SELECT_LSB +: 2] = s.sleep_select;
        rd_word[wsyn_pkg::PMC_SUSPEND_BIT] = s.power == wsyn_pkg::WSYN_SUSPEND;
      end
      wsyn_pkg::ADDR_WAKE_CTRL_STATUS_ONE: begin
        rd_word[wsyn_pkg::W1_WIDTH-1:0] = s.en_one;
        rd_word[wsyn_pkg::W1_STS_LSB +: wsyn_pkg::W1_WIDTH] = s.sts_one;
      end
      wsyn_pkg::ADDR_WAKE_CTRL_STATUS_TWO: begin
        rd_word[wsyn_pkg::W2_WIDTH-1:0] = s.en_two;
        rd_word[wsyn_pkg::W2_STS_LSB +: wsyn_pkg::W2_WIDTH] = s.sts_two;
      end
      wsyn_pkg::ADDR_STATION_LOW: rd_word = s.station[31:0];
      wsyn_pkg::ADDR_STATION_HIGH: rd_word[15:0] = s.station[47:32];
      wsyn_pkg::ADDR_V4_SOURCE_MATCH: rd_word = s.v4_source_match;
      wsyn_pkg::ADDR_V4_DEST_MATCH: rd_word = s.v4_dest_match;
      wsyn_pkg::ADDR_V4_PORT_MATCH: rd_word = s.v4_port_match;
      wsyn_pkg::ADDR_V6_PORT_MATCH: rd_word = s.v6_port_match;
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < wsyn_pkg::V6_WORDS; i++) begin
          if (paddr_in == wsyn_pkg::ADDR_V6_SOURCE_MATCH + 8'(i) * wsyn_pkg::ADDR_WORD_STEP) begin
            rd_word = s.v6_source_match[32*i +: 32];
            rd_hit = 1'b1;
          end
          if (paddr_in == wsyn_pkg::ADDR_V6_DEST_MATCH + 8'(i) * wsyn_pkg::ADDR_WORD_STEP) begin
            rd_word = s.v6_dest_match[32*i +: 32];
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  function automatic logic is_ext_header(input logic [7:0] code);
    is_ext_header = (code == wsyn_pkg::NH_HOP_BY_HOP) || (code == wsyn_pkg::NH_ROUTING) ||
                    (code == wsyn_pkg::NH_DEST_OPTS);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    // One wait state: data and error are ready with pready
    next_s.pready = access && !s.pready;
    next_s.prdata = rd_word;
    next_s.pslverr = !rd_hit;
    if (wr) begin
      case (paddr_in)
        wsyn_pkg::ADDR_POWER_MGMT_CONTROL: begin
          next_s.sleep_select = pwdata_in[wsyn_pkg::PMC_SELECT_LSB +: 2];
          if (pwdata_in[wsyn_pkg::PMC_SUSPEND_BIT]) begin
            next_s.power = wsyn_pkg::WSYN_SUSPEND;
          end
        end
        wsyn_pkg::ADDR_WAKE_CTRL_STATUS_ONE: begin
          next_s.en_one = pwdata_in[wsyn_pkg::W1_WIDTH-1:0];
          next_s.sts_one = s.sts_one & ~pwdata_in[wsyn_pkg::W1_STS_LSB +: wsyn_pkg::W1_WIDTH];
        end
        wsyn_pkg::ADDR_WAKE_CTRL_STATUS_TWO: begin
          next_s.en_two = pwdata_in[wsyn_pkg::W2_WIDTH-1:0];
          next_s.sts_two = s.sts_two & ~pwdata_in[wsyn_pkg::W2_STS_LSB +: wsyn_pkg::W2_WIDTH];
        end
        wsyn_pkg::ADDR_STATION_LOW: next_s.station[31:0] = pwdata_in;
        wsyn_pkg::ADDR_STATION_HIGH: next_s.station[47:32] = pwdata_in[15:0];
        wsyn_pkg::ADDR_V4_SOURCE_MATCH: next_s.v4_source_match = pwdata_in;
        wsyn_pkg::ADDR_V4_DEST_MATCH: next_s.v4_dest_match = pwdata_in;
        wsyn_pkg::ADDR_V4_PORT_MATCH: next_s.v4_port_match = pwdata_in;
        wsyn_pkg::ADDR_V6_PORT_MATCH: next_s.v6_port_match = pwdata_in;
        default: begin
          for (int i = 0; i < wsyn_pkg::V6_WORDS; i++) begin
            if (paddr_in == wsyn_pkg::ADDR_V6_SOURCE_MATCH + 8'(i) * wsyn_pkg::ADDR_WORD_STEP) begin
              next_s.v6_source_match[32*i +: 32] = pwdata_in;
            end
            if (paddr_in == wsyn_pkg::ADDR_V6_DEST_MATCH + 8'(i) * wsyn_pkg::ADDR_WORD_STEP) begin
              next_s.v6_dest_match[32*i +: 32] = pwdata_in;
            end
          end
        end
      endcase
    end
    // A wake in the clearing cycle keeps its status bit
    next_s.sts_one = next_s.sts_one | set_one;
    next_s.sts_two = next_s.sts_two | set_two;
    next_s.remote_wakeup = any_wake;
    if (any_wake) begin
      next_s.power = wsyn_pkg::WSYN_NORMAL;
    end

    // Parser
    if (rx_valid_in) begin
      if (idx != 14'h3FFF) begin
        next_s.cnt = idx + 14'h0001;
      end
      if (rx_sof_in) begin
        next_s.ip_ok = 1'b0;
        next_s.nh = 8'hFF;
        next_s.ext_pending = 1'b0;
        next_s.syn = 1'b0;
        next_s.l4_start = 14'h3FFF;
        next_s.started_normal = s.power == wsyn_pkg::WSYN_NORMAL;
      end
      if (idx == wsyn_pkg::OFS_ETYPE_HI || idx == wsyn_pkg::OFS_ETYPE_LO) begin
        next_s.etype = {s.etype[7:0], rx_data_in};
      end
      if (idx == wsyn_pkg::OFS_IP) begin
        if (is_v4) begin
          next_s.ip_ok = rx_data_in[7:4] == wsyn_pkg::IP_VER_4 && rx_data_in[3:0] >= wsyn_pkg::V4_MIN_IHL;
          next_s.l4_start = wsyn_pkg::OFS_IP + {8'h00, rx_data_in[3:0], 2'b00};
        end else begin
          next_s.ip_ok = is_v6 && rx_data_in[7:4] == wsyn_pkg::IP_VER_6;
          next_s.l4_start = wsyn_pkg::OFS_V6_L4;
        end
      end
      if ((is_v4 && idx == wsyn_pkg::OFS_V4_PROTO) || (is_v6 && idx == wsyn_pkg::OFS_V6_NH)) begin
        next_s.nh = rx_data_in;
      end
      // Walk the IPv6 extension chain, eight bytes per length unit
      if (is_v6 && !s.ext_pending && idx == s.l4_start && is_ext_header(s.nh)) begin
        next_s.nh = rx_data_in;
        next_s.ext_pending = 1'b1;
      end
      if (s.ext_pending && idx == s.l4_start + 14'h0001) begin
        next_s.l4_start = s.l4_start + {3'b000, rx_data_in, 3'b000} + wsyn_pkg::EXT_UNIT;
        next_s.ext_pending = 1'b0;
      end
      if (l4_ready && idx == s.l4_start + wsyn_pkg::OFS_TCP_FLAGS) begin
        next_s.syn = rx_data_in[wsyn_pkg::TCP_SYN_BIT];
      end
    end

    // Suspended frames go to the FIFO only when storing is on; FIFO drops those left unkept
    next_s.fifo_valid = rx_valid_in &&
                        ((rx_sof_in ? (s.power == wsyn_pkg::WSYN_NORMAL) : s.started_normal) ||
                         s.en_one[wsyn_pkg::W1_STORE_WAKE]);
    next_s.fifo_data = rx_data_in;
    next_s.fifo_last = frame_end;
    next_s.fifo_keep = frame_end && ((rx_sof_in ? (s.power == wsyn_pkg::WSYN_NORMAL) : s.started_normal) ||
                                     any_wake);
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata_out = s.prdata;
  assign pready_out = s.pready;
  assign pslverr_out = s.pslverr;
  assign fifo_valid_out = s.fifo_valid;
  assign fifo_data_out = s.fifo_data;
  assign fifo_last_out = s.fifo_last;
  assign fifo_keep_out = s.fifo_keep;
  assign remote_wakeup_out = s.remote_wakeup;
  assign suspended_out = s.power == wsyn_pkg::WSYN_SUSPEND;

endmodule
`default_nettype wire

// file: design/wsyn_pkg.sv
// Constants, types and register map of the TCP SYN wake detector
//
// Overview of operation
// - IPv4 SYN check needs enable and suspend 0/1/3
// - IPv4 frames to own, multicast or broadcast
// - IPv4 protocol field must indicate TCP
// - IPv4 wake needs SYN, addresses, ports matching
// - IPv4 wake sets status, resumes, remote wakeup
// - IPv4 needs good header, TCP checksums, FCS
// - IPv6 SYN check needs enable and suspend 0/1/3
// - IPv6 frames to own, multicast or broadcast
// - TCP found in base or extension header
// - IPv6 wake needs SYN, addresses, ports matching
// - IPv6 wake sets status, resumes, remote wakeup
// - IPv6 needs good TCP checksum and FCS
// - Zero match register forces its comparison true
// - All satisfied wake conditions set their status
// - Store wake frame and later frames in FIFO
// - Standby wakes on frames, link, GPIO, SYN
package wsyn_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_POWER_MGMT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_WAKE_CTRL_STATUS_ONE = 8'h04;
  localparam logic [7:0] ADDR_WAKE_CTRL_STATUS_TWO = 8'h08;
  localparam logic [7:0] ADDR_STATION_LOW = 8'h0C;
  localparam logic [7:0] ADDR_STATION_HIGH = 8'h10;
  localparam logic [7:0] ADDR_V4_SOURCE_MATCH = 8'h14;
  localparam logic [7:0] ADDR_V4_DEST_MATCH = 8'h18;
  localparam logic [7:0] ADDR_V4_PORT_MATCH = 8'h1C;
  localparam logic [7:0] ADDR_V6_SOURCE_MATCH = 8'h20;
  localparam logic [7:0] ADDR_V6_DEST_MATCH = 8'h30;
  localparam logic [7:0] ADDR_V6_PORT_MATCH = 8'h40;
  localparam logic [7:0] ADDR_WORD_STEP = 8'h04;
  localparam int V6_WORDS = 4;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int PMC_SELECT_LSB = 0;
  localparam int PMC_SUSPEND_BIT = 2;
  localparam logic [1:0] SLEEP_STATE_TWO = 2'h2;
  localparam int W1_BCAST = 0;
  localparam int W1_PERFECT_DA = 1;
  localparam int W1_STORE_WAKE = 2;
  localparam int W1_EXT_LSB = 3;
  localparam int EXT_EVENTS = 5;
  localparam int W1_WIDTH = 8;
  localparam int W1_STS_LSB = 8;
  localparam int W2_V4 = 0;
  localparam int W2_V6 = 1;
  localparam int W2_WIDTH = 2;
  localparam int W2_STS_LSB = 8;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [13:0] OFS_ETYPE_HI = 14'h000C;
  localparam logic [13:0] OFS_ETYPE_LO = 14'h000D;
  localparam logic [13:0] OFS_IP = 14'h000E;
  localparam logic [13:0] OFS_DA_END = 14'h0006;
  localparam logic [13:0] OFS_V4_PROTO = 14'h0017;
  localparam logic [13:0] OFS_V4_SRC = 14'h001A;
  localparam logic [13:0] OFS_V4_DST = 14'h001E;
  localparam logic [13:0] OFS_V6_NH = 14'h0014;
  localparam logic [13:0] OFS_V6_SRC = 14'h0016;
  localparam logic [13:0] OFS_V6_DST = 14'h0026;
  localparam logic [13:0] OFS_V6_L4 = 14'h0036;
  localparam logic [13:0] LEN_V4_ADDR = 14'h0004;
  localparam logic [13:0] LEN_V6_ADDR = 14'h0010;
  localparam logic [13:0] LEN_PORTS = 14'h0004;
  localparam logic [13:0] OFS_TCP_FLAGS = 14'h000D;
  localparam logic [13:0] EXT_UNIT = 14'h0008;
  localparam int TCP_SYN_BIT = 1;
  localparam logic [15:0] ETYPE_V4 = 16'h0800;
  localparam logic [15:0] ETYPE_V6 = 16'h86DD;
  localparam logic [3:0] IP_VER_4 = 4'h4;
  localparam logic [3:0] IP_VER_6 = 4'h6;
  localparam logic [3:0] V4_MIN_IHL = 4'h5;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] NH_HOP_BY_HOP = 8'h00;
  localparam logic [7:0] NH_ROUTING = 8'h2B;
  localparam logic [7:0] NH_DEST_OPTS = 8'h3C;
  localparam int DA_MCAST_BIT = 40;

  typedef enum logic {WSYN_NORMAL, WSYN_SUSPEND} wsyn_power_type;

endpackage

// file: design/wsyn_rx_if.sv
// Receive byte stream shared between the detector and its field grabbers
`timescale 1ns/1ps
`default_nettype none
interface wsyn_rx_if;
  logic valid;
  logic [7:0] data;
  logic sof;
  logic eof;
  modport source (output valid, output data, output sof, output eof);
  modport sink (input valid, input data, input sof, input eof);
endinterface
`default_nettype wire

// file: design/wsyn_field_cmp.sv
// Match register comparator with zero-forces-match behaviour
`timescale 1ns/1ps
`default_nettype none
module wsyn_field_cmp #(
  parameter int WIDTH = 32
) (
  // Programmed value and packet field
  input wire logic [WIDTH-1:0] match_in,
  input wire logic [WIDTH-1:0] value_in,
  // Result
  output logic hit_out
);
  // Zero can never be a useful address or port pair, so it means don't care
  assign hit_out = (match_in == '0) || (match_in == value_in);
endmodule
`default_nettype wire

// file: design/wsyn_field_grab.sv
// Shift register that collects a packet field while its window is open
`timescale 1ns/1ps
`default_nettype none
module wsyn_field_grab #(
  parameter int BYTES = 4
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Byte stream and window
  wsyn_rx_if.sink rx,
  input wire logic take_in,
  // Collected field, first byte most significant
  output logic [BYTES*8-1:0] field_out
);
  typedef struct packed {
    logic [BYTES*8-1:0] field;
  } wsyn_grab_type;

  wsyn_grab_type s;
  wsyn_grab_type next_s;

  always_comb begin
    next_s = s;
    if (rx.valid && take_in) begin
      next_s.field = {s.field[BYTES*8-9:0], rx.data};
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign field_out = s.field;
endmodule
`default_nettype wire

// file: verif/wsyn_props.sv
// Port-level assertions for the SYN wake detector
`timescale 1ns/1ps
`default_nettype none
module wsyn_props (
  // Watched ports
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_eof_in,
  input wire logic rx_fcs_ok_in,
  input wire logic [4:0] wake_event_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic fifo_valid_out,
  input wire logic [7:0] fifo_data_out,
  input wire logic remote_wakeup_out,
  input wire logic suspended_out
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_ready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready not one wait state");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than a cycle");
  a_error_zero: assert property (pready_out && pslverr_out |-> prdata_out == 32'h0)
    else $error("refused read returned data");
  a_wake_pulse: assert property (remote_wakeup_out |=> !remote_wakeup_out)
    else $error("wakeup pulse too long");
  a_wake_resumes: assert property (remote_wakeup_out |-> !suspended_out && $past(suspended_out))
    else $error("wakeup without resume");
  a_wake_cause: assert property ($rose(remote_wakeup_out) |-> $past(rx_valid_in && rx_eof_in || |wake_event_in))
    else $error("wakeup without cause");
  a_bad_fcs: assert property (rx_valid_in && rx_eof_in && !rx_fcs_ok_in && wake_event_in == 5'h0 |=> !remote_wakeup_out)
    else $error("wake on bad frame");
  a_awake_quiet: assert property (!suspended_out |=> !remote_wakeup_out)
    else $error("wake while not suspended");
  a_fifo_copy: assert property (rx_valid_in && !suspended_out |=> fifo_valid_out && fifo_data_out == $past(rx_data_in))
    else $error("byte not forwarded");
endmodule
`default_nettype wire

// file: verif/wsyn_mac_model.sv
// Receive-path model of the MAC feeding frames byte by byte
`timescale 1ns/1ps
`default_nettype none
module wsyn_mac_model (
  // Clock
  input wire logic clock_in,
  // Receive stream
  output logic valid_out,
  output logic [7:0] data_out,
  output logic sof_out,
  output logic eof_out,
  output logic [2:0] ok_out
);
  initial begin
    valid_out = 1'b0;
    data_out = 8'hA5;
    sof_out = 1'b0;
    eof_out = 1'b0;
    ok_out = 3'h0;
  end
  // ****************************************
  // Frame sender, optionally with gaps
  // ****************************************
  task automatic send(input logic [7:0] f[$], input logic [2:0] ok, input bit slow);
    for (int i = 0; i < f.size(); i++) begin
      @(posedge clock_in);
      valid_out <= 1'b1;
      data_out <= f[i];
      sof_out <= (i == 0);
      eof_out <= (i == f.size() - 1);
      // Check results mean nothing before eof, so show junk
      ok_out <= (i == f.size() - 1) ? ok : ~ok;
      if (slow) begin
        @(posedge clock_in);
        valid_out <= 1'b0;
        data_out <= ~f[i];
      end
    end
    @(posedge clock_in);
    valid_out <= 1'b0;
    eof_out <= 1'b0;
    data_out <= ~data_out;
    ok_out <= ~ok;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the SYN wake detector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // Signals and model state
  // ****************************************
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwd = 32'h0, r, ra, rb, pt, m4s;
  wire [31:0] prd;
  wire [7:0] rd8, fd;
  wire [2:0] ok3;
  wire prdy, perr, rv, rs, re, fv, fl, fk, wk, sp;
  logic [1:0] en, s2, sel;
  bit susp, st, bc, s1;
  int errors = 0, checks_done = 0, wakes = 0, ewk = 0, fb = 0, efb = 0;
  logic [7:0] f[$];
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (wk === 1'b1) wakes++;
    if (fv === 1'b1) fb++;
  end
  wsyn_mac_model mac_u (.clock_in(clk), .valid_out(rv), .data_out(rd8), .sof_out(rs), .eof_out(re), .ok_out(ok3));
  wsyn_detector dut_u (.clock_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .rx_valid_in(rv), .rx_data_in(rd8), .rx_sof_in(rs), .rx_eof_in(re), .rx_fcs_ok_in(ok3[2]),
    .rx_ip_csum_ok_in(ok3[1]), .rx_tcp_csum_ok_in(ok3[0]), .wake_event_in(5'h00), .fifo_valid_out(fv),
    .fifo_data_out(fd), .fifo_last_out(fl), .fifo_keep_out(fk), .remote_wakeup_out(wk), .suspended_out(sp));
  // ****************************************
  // Tasks
  // ****************************************
  task summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1) begin
      errors++;
      summarize();
    end
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task rst_all;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    {susp, sel, en, s2, s1, bc, st, m4s} = '0;
  endtask
  task p4(input logic [31:0] v);
    for (int i = 3; i >= 0; i--) f.push_back(v[i*8+:8]);
  endtask
  task go(input bit v6, bd, input logic [7:0] pr, input bit sy, input logic [31:0] sr, input logic [2:0] ok, input bit sl);
    bit h, h4, h6, hb;
    f = {};
    p4(bd ? 32'hFFFFFFFF : 32'h02000000);
    p4({bd ? 16'hFFFF : 16'h0001, 16'h0200});
    p4(32'h0);
    p4({v6 ? 16'h86DD : 16'h0800, v6 ? 16'h6000 : 16'h4500});
    if (v6) begin
      p4(32'h20);
      f.push_back(8'h00);
      f.push_back(8'h40);
      repeat (4) p4(sr);
      repeat (4) p4(rb);
      p4({pr, 24'h0});
      p4(32'h0);
    end else begin
      p4(32'h00280000);
      p4({24'h40, pr});
      f.push_back(8'h00);
      f.push_back(8'h00);
      p4(sr);
      p4(rb);
    end
    p4(pt);
    p4(32'h0);
    p4(32'h0);
    p4({8'h50, 6'h0, sy, 1'b0, 16'hFFFF});
    p4(32'h0);
    h = susp && sel != 2'h2 && bd && ok[2] && ok[0] && pr == 8'h06 && sy;
    h4 = h && !v6 && en[0] && ok[1] && (m4s == 32'h0 || m4s == sr);
    h6 = h && v6 && en[1];
    hb = susp && sel != 2'h2 && bc && bd && ok[2];
    if (!susp || st) efb += f.size();
    if (h4 || h6 || hb) ewk++;
    if (h4 || h6 || hb) susp = 1'b0;
    s2 |= {h6, h4};
    s1 |= hb;
    mac_u.send(f, ok, sl);
    repeat (3) @(posedge clk);
    rd(8'h08, {22'h0, s2, 6'h0, en});
    rd(8'h04, {22'h0, 1'b0, s1, 5'h0, st, 1'b0, bc});
    rd(8'h00, {29'h0, susp, sel});
    chk(wakes, ewk);
    chk(fb, efb);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    ra = $urandom(69714) | 32'h1;
    rb = $urandom;
    pt = $urandom;
    rst_all();
    rd(8'h08, 32'h0);
    apb(1'b0, 8'h50, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h14, ra);
    apb(1'b1, 8'h18, rb);
    apb(1'b1, 8'h1C, pt);
    m4s = ra;
    apb(1'b1, 8'h08, 32'h1);
    en = 2'h1;
    apb(1'b1, 8'h00, 32'h4);
    susp = 1'b1;
    go(1'b0, 1'b1, 8'h11, 1'b1, ra, 3'h7, 1'b0);
    go(1'b0, 1'b1, 8'h06, 1'b0, ra, 3'h7, 1'b0);
    go(1'b0, 1'b1, 8'h06, 1'b1, ra ^ 32'h2, 3'h7, 1'b0);
    go(1'b0, 1'b1, 8'h06, 1'b1, ra, 3'h3, 1'b0);
    go(1'b0, 1'b1, 8'h06, 1'b1, ra, 3'h5, 1'b0);
    go(1'b0, 1'b0, 8'h06, 1'b1, ra, 3'h7, 1'b0);
    go(1'b0, 1'b1, 8'h06, 1'b1, ra, 3'h7, 1'b0);
    apb(1'b1, 8'h08, 32'h302);
    {s2, en} = 4'h2;
    apb(1'b1, 8'h00, 32'h7);
    {susp, sel} = 3'h7;
    go(1'b1, 1'b1, 8'h06, 1'b1, $urandom, 3'h5, 1'b1);
    apb(1'b1, 8'h08, 32'h303);
    {s2, en} = 4'h3;
    apb(1'b1, 8'h00, 32'h6);
    {susp, sel} = 3'h6;
    go(1'b0, 1'b1, 8'h06, 1'b1, ra, 3'h7, 1'b0);
    rst_all();
    apb(1'b1, 8'h04, 32'h5);
    {st, bc} = 2'h3;
    apb(1'b1, 8'h08, 32'h1);
    en = 2'h1;
    apb(1'b1, 8'h00, 32'h5);
    {susp, sel} = 3'h5;
    go(1'b0, 1'b1, 8'h06, 1'b1, $urandom, 3'h7, 1'b0);
    apb(1'b1, 8'h04, 32'h104);
    {s1, bc} = 2'h0;
    apb(1'b1, 8'h08, 32'h100);
    {s2, en} = 4'h0;
    go(1'b0, 1'b1, 8'h06, 1'b1, ra, 3'h7, 1'b1);
    summarize();
  end
endmodule
bind wsyn_detector wsyn_props chk_u (.clock_in, .rst_n_in, .psel_in, .penable_in, .rx_valid_in, .rx_data_in,
  .rx_eof_in, .rx_fcs_ok_in, .wake_event_in, .prdata_out, .pready_out, .pslverr_out, .fifo_valid_out,
  .fifo_data_out, .remote_wakeup_out, .suspended_out);
`default_nettype wire
